// *** include/cts_pkg.sv ***
package cts_pkg;
    localparam logic [6:0]  DEV_ADDR         = 7'h6c;
    localparam logic [7:0]  RUN_ADDR         = 8'h02;
    localparam logic [7:0]  MUTE_ADDR        = 8'h03;
    localparam logic [7:0]  VOLUME_ADDR      = 8'h04;
    localparam logic [7:0]  STATUS_ADDR      = 8'h05;
    localparam logic [7:0]  CLIP_MID_ADDR    = 8'h10;
    localparam logic [7:0]  CLIP_LOW_ADDR    = 8'h11;
    localparam logic [7:0]  CLIP_HIGH_ADDR   = 8'h12;
    localparam int          CLIP_LOW_LSB     = 2;
    localparam int          RUN_BIT          = 0;
    localparam int          MUTE_BIT         = 0;
    localparam int          STAT_ACTIVE_BIT  = 0;
    localparam int          STAT_SWMODE_BIT  = 1;
    localparam logic [1:0]  SW_MODE_CODE     = 2'h3;
    localparam logic        RUN_RESET        = 1'h1;
    localparam logic        MUTE_RESET       = 1'h0;
    localparam logic [7:0]  VOLUME_RESET     = 8'h80;
    localparam int          VOLUME_SHIFT     = 7;
    localparam logic [5:0]  CLIP_HIGH_RESET  = 6'h3f;
    localparam logic [7:0]  CLIP_MID_RESET   = 8'hff;
    localparam logic [5:0]  CLIP_LOW_RESET   = 6'h3f;
    localparam logic [1:0]  CLIP_RSVD_RESET  = 2'h0;
    localparam logic [19:0] CLIP_LEVEL_RESET = {CLIP_HIGH_RESET, CLIP_MID_RESET, CLIP_LOW_RESET};

    typedef enum logic [3:0] {
        CTS_IDLE      = 4'b0000,
        CTS_ADDR      = 4'b0001,
        CTS_ADDR_ACK  = 4'b0010,
        CTS_PTR       = 4'b0011,
        CTS_PTR_ACK   = 4'b0100,
        CTS_WDATA     = 4'b0101,
        CTS_WDATA_ACK = 4'b0110,
        CTS_RDATA     = 4'b0111,
        CTS_RDATA_ACK = 4'b1000
    } cts_i2c_state_t;
endpackage

// *** verification/cts_host.sv ***
`timescale 1ns/1ps
module cts_host (
    // clock
    input  wire logic sys_clk,
    // control port wires
    input  wire logic sda,
    output logic      scl,
    output logic      sda_low,
    // shutdown pin
    output logic      speaker_shutdown_n
);
    logic       ack_seen;
    logic [7:0] rd_byte;

    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
        speaker_shutdown_n = 1'b0;
        ack_seen = 1'b0;
        rd_byte = 8'h00;
    end

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // one bit, scl high and low for four cycles each
    task automatic put_bit(input logic b, output logic seen);
        sda_low = !b;
        wait_cyc(2);
        scl = 1'b1;
        wait_cyc(2);
        seen = sda;
        wait_cyc(2);
        scl = 1'b0;
        wait_cyc(2);
    endtask

    task automatic put_byte(input logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            put_bit(b[i], s);
        end
        put_bit(1'b1, s);
        ack_seen = !s;
    endtask

    task automatic get_byte(input logic last);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            put_bit(1'b1, s);
            rd_byte[i] = s;
        end
        put_bit(last, s);
    endtask

    task automatic start_cond();
        sda_low = 1'b0;
        wait_cyc(2);
        scl = 1'b1;
        wait_cyc(2);
        sda_low = 1'b1;
        wait_cyc(2);
        scl = 1'b0;
        wait_cyc(2);
    endtask

    task automatic stop_cond();
        sda_low = 1'b1;
        wait_cyc(2);
        scl = 1'b1;
        wait_cyc(2);
        sda_low = 1'b0;
        wait_cyc(4);
    endtask

    // register programming kept to shutdown except mute, run and volume
    task automatic reg_write(input logic [7:0] ptr, input logic [7:0] data);
        start_cond();
        put_byte({cts_pkg::DEV_ADDR, 1'b0});
        put_byte(ptr);
        put_byte(data);
        stop_cond();
    endtask

    task automatic reg_read(input logic [7:0] ptr);
        start_cond();
        put_byte({cts_pkg::DEV_ADDR, 1'b0});
        put_byte(ptr);
        start_cond();
        put_byte({cts_pkg::DEV_ADDR, 1'b1});
        get_byte(1'b1);
        stop_cond();
    endtask

    // release only after programming and mute are done
    task automatic release_shutdown();
        speaker_shutdown_n = 1'b1;
    endtask

    // pin pulled low after mute, before clocks stop
    task automatic enter_shutdown();
        speaker_shutdown_n = 1'b0;
    endtask
endmodule

// *** verification/tb_cts_top.sv ***
`timescale 1ns/1ps
module tb_cts_top;
    logic        sys_clk;
    logic        rst_b;
    logic        clk_en;
    logic [1:0]  speaker_gain_select;
    logic        speaker_shutdown_n;
    logic        scl;
    logic        sda_low;
    logic        sda_line;
    logic        sda_out;
    logic        sda_oe;
    logic [23:0] sample_in;
    logic        sample_in_valid;
    logic [23:0] sample_out;
    logic        sample_out_valid;
    logic        software_mode;
    logic        device_active;
    logic [19:0] clip_threshold_level;
    int          miscompares;
    int          checked;
    int          cycles;

    // pulled-up wire, low when either side pulls
    assign sda_line = !(sda_low || sda_oe);

    cts_top i_cts_top (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en),
        .speaker_gain_select(speaker_gain_select), .speaker_shutdown_n(speaker_shutdown_n),
        .bridge_mode_or_serial_clock(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
        .sample_in(sample_in), .sample_in_valid(sample_in_valid), .sample_out(sample_out),
        .sample_out_valid(sample_out_valid), .software_mode(software_mode),
        .device_active(device_active), .clip_threshold_level(clip_threshold_level));

    cts_host i_cts_host (.sys_clk(sys_clk), .sda(sda_line), .scl(scl), .sda_low(sda_low),
        .speaker_shutdown_n(speaker_shutdown_n));

    always #4 sys_clk = !sys_clk;

    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic check(input logic [24:0] seen, input logic [24:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        if (miscompares == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // one sample in, output seen one cycle later
    task automatic play(input logic [23:0] s);
        step(1);
        sample_in = s;
        sample_in_valid = 1'b1;
        step(1);
        sample_in_valid = 1'b0;
    endtask

    task automatic read_check(input logic [7:0] ptr, input logic [7:0] exp);
        i_cts_host.reg_read(ptr);
        check({17'h00000, i_cts_host.rd_byte}, {17'h00000, exp});
    endtask

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 30000) begin
            miscompares++;
            finish_test();
        end
    end

    initial begin
        sys_clk = 1'b0;
        rst_b = 1'b0;
        clk_en = 1'b1;
        speaker_gain_select = 2'h3;
        sample_in = 24'h000000;
        sample_in_valid = 1'b0;
        miscompares = 0;
        checked = 0;
        cycles = 0;
        step(2);
        rst_b = 1'b1;
        step(2);
        check(software_mode, 1);
        read_check(cts_pkg::STATUS_ADDR, 8'h02);
        read_check(cts_pkg::CLIP_LOW_ADDR, 8'hfc);
        read_check(cts_pkg::CLIP_MID_ADDR, 8'hff);
        check(clip_threshold_level, 20'hfffff);
        i_cts_host.reg_write(cts_pkg::MUTE_ADDR, 8'h01);
        i_cts_host.reg_write(cts_pkg::CLIP_LOW_ADDR, 8'ha8);
        i_cts_host.reg_write(cts_pkg::CLIP_MID_ADDR, 8'h00);
        i_cts_host.reg_write(cts_pkg::CLIP_HIGH_ADDR, 8'h00);
        read_check(cts_pkg::CLIP_LOW_ADDR, 8'ha8);
        read_check(cts_pkg::CLIP_MID_ADDR, 8'h00);
        read_check(8'h20, 8'h00);
        check(clip_threshold_level, 20'h0002a);
        play(24'h000100);
        check({sample_out_valid, sample_out}, 25'h0000000);
        i_cts_host.release_shutdown();
        step(3);
        check(device_active, 1);
        play(24'h000100);
        check({sample_out_valid, sample_out}, 25'h1000000);
        i_cts_host.reg_write(cts_pkg::MUTE_ADDR, 8'h00);
        play(24'h000100);
        check({sample_out_valid, sample_out}, 25'h100002a);
        play(24'hffff00);
        check({sample_out_valid, sample_out}, 25'h1ffffd6);
        play(24'h000010);
        check({sample_out_valid, sample_out}, 25'h1000010);
        i_cts_host.reg_write(cts_pkg::VOLUME_ADDR, 8'h40);
        play(24'h000020);
        check({sample_out_valid, sample_out}, 25'h1000010);
        clk_en = 1'b0;
        play(24'h000004);
        check({sample_out_valid, sample_out}, 25'h1000010);
        clk_en = 1'b1;
        i_cts_host.reg_write(cts_pkg::RUN_ADDR, 8'h00);
        step(3);
        check(device_active, 0);
        play(24'h000020);
        check({sample_out_valid, sample_out}, 25'h0000000);
        i_cts_host.reg_write(cts_pkg::RUN_ADDR, 8'h01);
        step(3);
        check(device_active, 1);
        read_check(cts_pkg::STATUS_ADDR, 8'h03);
        i_cts_host.reg_write(cts_pkg::MUTE_ADDR, 8'h01);
        i_cts_host.enter_shutdown();
        step(3);
        check(device_active, 0);
        speaker_gain_select = 2'h1;
        rst_b = 1'b0;
        step(2);
        rst_b = 1'b1;
        step(3);
        check(software_mode, 0);
        i_cts_host.reg_read(cts_pkg::STATUS_ADDR);
        check(i_cts_host.ack_seen, 0);
        check(sda_out, 0);
        finish_test();
    end
endmodule

// *** verilog/cts_i2c.sv ***
`timescale 1ns/1ps
module cts_i2c (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst_b,
    input  wire logic       clk_en,
    input  wire logic       enable,
    // serial pins
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    // register access
    output logic            wr_en,
    output logic [7:0]      wr_addr,
    output logic [7:0]      wr_data,
    output logic [7:0]      rd_addr,
    input  wire logic [7:0] rd_data
);
    cts_pkg::cts_i2c_state_t state;
    logic       scl_q;
    logic       sda_q;
    logic [3:0] bitc;
    logic [7:0] shift;
    logic [7:0] tx;
    logic       rw;
    logic       nack;
    logic [7:0] ptr;

    wire scl_rise = scl_in && !scl_q;
    wire scl_fall = !scl_in && scl_q;
    wire start_c  = scl_in && scl_q && sda_q && !sda_in;
    wire stop_c   = scl_in && scl_q && !sda_q && sda_in;
    wire byte_in  = bitc == 4'h8;
    wire addr_hit = shift[7:1] == cts_pkg::DEV_ADDR;

    assign rd_addr = ptr;

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else if (clk_en) begin
            scl_q <= scl_in;
            sda_q <= sda_in;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            state   <= cts_pkg::CTS_IDLE;
            bitc    <= 4'h0;
            shift   <= 8'h00;
            tx      <= 8'h00;
            rw      <= 1'b0;
            nack    <= 1'b0;
            ptr     <= 8'h00;
            sda_out <= 1'b0;
            sda_oe  <= 1'b0;
            wr_en   <= 1'b0;
            wr_addr <= 8'h00;
            wr_data <= 8'h00;
        end else if (clk_en) begin
            wr_en <= 1'b0;
            if (!enable || stop_c) begin
                state  <= cts_pkg::CTS_IDLE;
                sda_oe <= 1'b0;
            end else if (start_c) begin
                state  <= cts_pkg::CTS_ADDR;
                bitc   <= 4'h0;
                sda_oe <= 1'b0;
            end else if (scl_rise) begin
                if (state == cts_pkg::CTS_RDATA_ACK) begin
                    nack <= sda_in;
                end else begin
                    shift <= {shift[6:0], sda_in};
                    bitc  <= bitc + 4'h1;
                end
            end else if (scl_fall) begin
                case (state)
                    cts_pkg::CTS_ADDR: begin
                        if (byte_in) begin
                            state  <= addr_hit ? cts_pkg::CTS_ADDR_ACK : cts_pkg::CTS_IDLE;
                            sda_oe <= addr_hit;
                            rw     <= shift[0];
                        end
                    end
                    cts_pkg::CTS_ADDR_ACK: begin
                        bitc <= 4'h0;
                        if (rw) begin
                            state  <= cts_pkg::CTS_RDATA;
                            tx     <= rd_data;
                            sda_oe <= !rd_data[7];
                        end else begin
                            state  <= cts_pkg::CTS_PTR;
                            sda_oe <= 1'b0;
                        end
                    end
                    cts_pkg::CTS_PTR: begin
                        if (byte_in) begin
                            ptr    <= shift;
                            state  <= cts_pkg::CTS_PTR_ACK;
                            sda_oe <= 1'b1;
                        end
                    end
                    cts_pkg::CTS_PTR_ACK, cts_pkg::CTS_WDATA_ACK: begin
                        if (state == cts_pkg::CTS_WDATA_ACK) begin
                            ptr <= ptr + 8'h01;
                        end
                        state  <= cts_pkg::CTS_WDATA;
                        bitc   <= 4'h0;
                        sda_oe <= 1'b0;
                    end
                    cts_pkg::CTS_WDATA: begin
                        if (byte_in) begin
                            wr_en   <= 1'b1;
                            wr_addr <= ptr;
                            wr_data <= shift;
                            state   <= cts_pkg::CTS_WDATA_ACK;
                            sda_oe  <= 1'b1;
                        end
                    end
                    cts_pkg::CTS_RDATA: begin
                        if (byte_in) begin
                            state  <= cts_pkg::CTS_RDATA_ACK;
                            sda_oe <= 1'b0;
                            ptr    <= ptr + 8'h01;
                        end else begin
                            tx     <= {tx[6:0], 1'b0};
                            sda_oe <= !tx[6];
                        end
                    end
                    cts_pkg::CTS_RDATA_ACK: begin
                        bitc <= 4'h0;
                        if (nack) begin
                            state <= cts_pkg::CTS_IDLE;
                        end else begin
                            state  <= cts_pkg::CTS_RDATA;
                            tx     <= rd_data;
                            sda_oe <= !rd_data[7];
                        end
                    end
                    default: begin
                        state <= cts_pkg::CTS_IDLE;
                    end
                endcase
            end
        end
    end
endmodule

// *** verilog/cts_top.sv ***
`timescale 1ns/1ps
module cts_top (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    input  wire logic        clk_en,
    // strap and control pins
    input  wire logic [1:0]  speaker_gain_select,
    input  wire logic        speaker_shutdown_n,
    // control port
    input  wire logic        bridge_mode_or_serial_clock,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    // audio samples in
    input  wire logic [23:0] sample_in,
    input  wire logic        sample_in_valid,
    // audio samples out
    output logic [23:0]      sample_out,
    output logic             sample_out_valid,
    // status
    output logic             software_mode,
    output logic             device_active,
    output logic [19:0]      clip_threshold_level
);
    logic       run_bit;
    logic       mute_bit;
    logic [7:0] volume;
    logic [5:0] clip_high;
    logic [7:0] clip_mid;
    logic [5:0] clip_low;
    logic [1:0] clip_rsvd;
    logic       host_wr;
    logic [7:0] host_wr_addr;
    logic [7:0] host_wr_data;
    logic [7:0] host_rd_addr;

    function automatic logic [23:0] clip_sample(input logic signed [25:0] v, input logic [19:0] lvl);
        logic signed [25:0] pos;
        pos = $signed({6'h00, lvl});
        if (v > pos) begin
            clip_sample = pos[23:0];
        end else if (v < -pos) begin
            clip_sample = 24'(-pos);
        end else begin
            clip_sample = v[23:0];
        end
    endfunction

    wire [7:0] status_byte = {6'h00, software_mode, device_active};
    wire [7:0] rd_data =
        (host_rd_addr == cts_pkg::RUN_ADDR)       ? {7'h00, run_bit} :
        (host_rd_addr == cts_pkg::MUTE_ADDR)      ? {7'h00, mute_bit} :
        (host_rd_addr == cts_pkg::VOLUME_ADDR)    ? volume :
        (host_rd_addr == cts_pkg::STATUS_ADDR)    ? status_byte :
        (host_rd_addr == cts_pkg::CLIP_HIGH_ADDR) ? {2'h0, clip_high} :
        (host_rd_addr == cts_pkg::CLIP_MID_ADDR)  ? clip_mid :
        (host_rd_addr == cts_pkg::CLIP_LOW_ADDR)  ? {clip_low, clip_rsvd} : 8'h00;

    cts_i2c u_i2c (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .clk_en  (clk_en),
        .enable  (software_mode),
        .scl_in  (bridge_mode_or_serial_clock),
        .sda_in  (sda_in),
        .sda_out (sda_out),
        .sda_oe  (sda_oe),
        .wr_en   (host_wr),
        .wr_addr (host_wr_addr),
        .wr_data (host_wr_data),
        .rd_addr (host_rd_addr),
        .rd_data (rd_data)
    );

    wire shutdown_now = !speaker_shutdown_n || !run_bit;
    wire wr_run       = host_wr && host_wr_addr == cts_pkg::RUN_ADDR;
    wire wr_mute      = host_wr && host_wr_addr == cts_pkg::MUTE_ADDR;
    wire wr_volume    = host_wr && host_wr_addr == cts_pkg::VOLUME_ADDR;
    wire wr_high      = host_wr && host_wr_addr == cts_pkg::CLIP_HIGH_ADDR;
    wire wr_mid       = host_wr && host_wr_addr == cts_pkg::CLIP_MID_ADDR;
    wire wr_low       = host_wr && host_wr_addr == cts_pkg::CLIP_LOW_ADDR;
    wire [19:0] next_clip_level = {clip_high, clip_mid, clip_low};

    wire signed [32:0] scaled     = $signed(sample_in) * $signed({1'b0, volume});
    wire signed [25:0] scaled_sh  = scaled[32:7];
    wire [23:0]        next_out   = clip_sample(scaled_sh, clip_threshold_level);
    wire               out_silent = mute_bit || shutdown_now;

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            software_mode <= 1'b0;
            device_active <= 1'b0;
        end else if (clk_en) begin
            software_mode <= speaker_gain_select == cts_pkg::SW_MODE_CODE;
            device_active <= !shutdown_now;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            run_bit  <= cts_pkg::RUN_RESET;
            mute_bit <= cts_pkg::MUTE_RESET;
            volume   <= cts_pkg::VOLUME_RESET;
        end else if (clk_en) begin
            if (wr_run) begin
                run_bit <= host_wr_data[cts_pkg::RUN_BIT];
            end
            if (wr_mute) begin
                mute_bit <= host_wr_data[cts_pkg::MUTE_BIT];
            end
            if (wr_volume) begin
                volume <= host_wr_data;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            clip_high <= cts_pkg::CLIP_HIGH_RESET;
            clip_mid  <= cts_pkg::CLIP_MID_RESET;
            clip_low  <= cts_pkg::CLIP_LOW_RESET;
            clip_rsvd <= cts_pkg::CLIP_RSVD_RESET;
        end else if (clk_en) begin
            if (wr_high) begin
                clip_high <= host_wr_data[5:0];
            end
            if (wr_mid) begin
                clip_mid <= host_wr_data;
            end
            if (wr_low) begin
                clip_low  <= host_wr_data[7:cts_pkg::CLIP_LOW_LSB];
                clip_rsvd <= host_wr_data[1:0];
            end
        end
    end

    // threshold in use only moves while the device is shut down
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            clip_threshold_level <= cts_pkg::CLIP_LEVEL_RESET;
        end else if (clk_en && shutdown_now) begin
            clip_threshold_level <= next_clip_level;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            sample_out       <= 24'h000000;
            sample_out_valid <= 1'b0;
        end else if (clk_en) begin
            sample_out_valid <= sample_in_valid && !shutdown_now;
            sample_out       <= out_silent ? 24'h000000 : next_out;
        end
    end

    wire [23:0] out_mag = sample_out[23] ? 24'(-sample_out) : sample_out;

    low_field_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (clk_en && wr_low) |=> (host_rd_addr != cts_pkg::CLIP_LOW_ADDR
            || rd_data[7:2] == $past(host_wr_data[7:2])))
        else $error("low threshold field not stored");
    mid_field_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (clk_en && wr_mid) |=> clip_mid == $past(host_wr_data))
        else $error("middle threshold field not stored");
    clip_limit_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        ($past(clk_en) && sample_out_valid) |-> out_mag <= {4'h0, $past(clip_threshold_level)})
        else $error("output exceeds clip threshold");
    level_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (clk_en && !shutdown_now) |=> $stable(clip_threshold_level))
        else $error("threshold moved outside shutdown");
    mute_silence_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (clk_en && out_silent) |=> sample_out == 24'h000000)
        else $error("audio leaks while muted or shut down");
    audio_flow_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (clk_en && !shutdown_now && sample_in_valid) |=> sample_out_valid)
        else $error("audio not passed in normal operation");
    shutdown_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (clk_en && (!speaker_shutdown_n || !run_bit)) |=> !device_active ##1 (!device_active || $past(clk_en)))
        else $error("device active while shutdown requested");
    volume_live_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (clk_en && wr_volume && !shutdown_now) |=> volume == $past(host_wr_data))
        else $error("volume not applied during operation");
    mode_select_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clk_en |=> software_mode == ($past(speaker_gain_select) == cts_pkg::SW_MODE_CODE))
        else $error("software mode decode wrong");

    // setting storage
    run_write_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (clk_en && wr_run) |=> run_bit == $past(host_wr_data[cts_pkg::RUN_BIT]))
        else $error("run bit not stored");
    mute_write_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (clk_en && wr_mute) |=> mute_bit == $past(host_wr_data[cts_pkg::MUTE_BIT]))
        else $error("mute bit not stored");
    high_field_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (clk_en && wr_high) |=> clip_high == $past(host_wr_data[5:0]))
        else $error("upper threshold field not stored");
    rsvd_field_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (clk_en && wr_low) |=> clip_rsvd == $past(host_wr_data[1:0]))
        else $error("reserved bits not stored");

    // threshold load and clip edges
    level_load_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (clk_en && shutdown_now) |=> clip_threshold_level == $past({clip_high, clip_mid, clip_low}))
        else $error("threshold not loaded in shutdown");
    clip_reach_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (clk_en && !out_silent && scaled_sh > $signed({6'h00, clip_threshold_level}))
            |=> sample_out == {4'h0, $past(clip_threshold_level)})
        else $error("positive clip level not reached");
    clip_floor_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (clk_en && !out_silent && scaled_sh < -$signed({6'h00, clip_threshold_level}))
            |=> sample_out == 24'h000000 - {4'h0, $past(clip_threshold_level)})
        else $error("negative clip level not reached");
    clip_inside_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (clk_en && !out_silent && scaled_sh <= $signed({6'h00, clip_threshold_level})
            && scaled_sh >= -$signed({6'h00, clip_threshold_level})) |=> sample_out == $past(scaled_sh[23:0]))
        else $error("in-range sample altered");

    // shutdown, freeze and pin release
    valid_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (clk_en && shutdown_now) |=> !sample_out_valid)
        else $error("sample valid while shut down");
    run_active_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (clk_en && speaker_shutdown_n && run_bit) |=> device_active)
        else $error("device idle although released");
    enable_freeze_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !clk_en |=> $stable(device_active) && $stable(sample_out) && $stable(clip_threshold_level))
        else $error("state moved while clock enable low");
    sda_release_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (clk_en && !software_mode) |=> !sda_oe)
        else $error("data line pulled outside software mode");
endmodule
